//--- tb/test_table_write_skip_xor_ops.sv
// Self-checking bench: APB register access and instruction execution.
// Assumes one wait state on APB and the far model answering reads at once.
`default_nettype none

module test_table_write_skip_xor_ops
	import tws_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, iv = 0, tw = 0, er;
	logic pready, pslverr, irdy, hwe, dsc;
	logic [7:0] paddr = 0, rfd, hdata;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [15:0] ins = 0;
	logic [11:0] rfa, ibase = 0, zaddr = 12'hfff;
	logic [20:0] haddr, p, pe, wa;
	logic [20:0] starts [4] = '{21'h12_3456, 21'h1f_ffff, 21'h00_0000, 21'h01_389a};
	logic [7:0] offs [6] = '{OFS_ACC, OFS_STATUS, OFS_POINTER, OFS_LATCH, OFS_BANK, OFS_CTRL};
	int errors = 0, num_checks = 0, cyc = 0;

	always #5 clk = ~clk;

	tws_core tws_core_i (.I_CLOCK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_INSTR_VALID(iv), .I_INSTR(ins),
		.I_NEXT_TWO_WORD(tw), .O_INSTR_READY(irdy), .O_RF_ADDR(rfa), .I_RF_DATA(rfd),
		.I_INDEX_BASE(ibase), .O_HOLD_WE(hwe), .O_HOLD_ADDR(haddr), .O_HOLD_DATA(hdata),
		.O_DISCARD(dsc));
	tws_far_model tws_far_model_i (.i_clock(clk), .i_hold_we(hwe), .i_hold_addr(haddr),
		.i_hold_data(hdata), .i_rf_addr(rfa), .i_zero_addr(zaddr), .o_rf_data(rfd));

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		pen <= 0;
	endtask : apb

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
		apb(0, a, 0);
		chk(nm, rd, x);
		chk("slverr", er, 0);
	endtask : rdc

	// Offer one opcode, then count edges until the sequencer is free again
	task automatic run(input logic [15:0] op, input logic t, input int busy, input logic sk);
		int n;
		logic d;
		n = 0;
		d = 0;
		@(posedge clk);
		iv <= 1;
		ins <= op;
		tw <= t;
		do @(posedge clk); while (irdy !== 1'b1);
		iv <= 0;
		do
		begin
			@(posedge clk);
			n++;
			d |= (dsc === 1'b1);
		end
		while (irdy !== 1'b1);
		chk("cycles", n, busy + 1);
		chk("discard", d, sk);
	endtask : run

	task automatic tst(input logic a, input logic [7:0] f, input logic [3:0] bk,
		input logic x, input logic [11:0] z, input logic t, input int busy);
		apb(1, OFS_BANK, bk);
		apb(1, OFS_CTRL, x);
		zaddr <= z;
		run({TST_OPC, a, f}, t, busy, busy > 1);
	endtask : tst

	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			errors++;
			summarize();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		srst <= 0;
		foreach (offs[i]) rdc("reset", offs[i], 0);
		apb(0, 8'h18, 0);
		chk("unmapped err", er, 1);
		chk("unmapped data", rd, 0);
		// Xor: plain, zero result, negative result
		apb(1, OFS_ACC, 32'hb5);
		apb(1, OFS_STATUS, 32'h1f);
		run(16'h0aaf, 0, 1, 0);
		rdc("acc", OFS_ACC, 32'h1a);
		rdc("status", OFS_STATUS, 32'h0b);
		run(16'h0a1a, 0, 1, 0);
		rdc("acc", OFS_ACC, 0);
		rdc("status", OFS_STATUS, 32'h0f);
		run(16'h0a80, 0, 1, 0);
		rdc("status", OFS_STATUS, 32'h1b);
		// Neighbouring upper byte is not xor: taken at once, accumulator kept
		run(16'h0b80, 0, 0, 0);
		rdc("acc", OFS_ACC, 32'h80);
		// Table write in all four pointer modes, wrap at both ends
		for (int m = 0; m < 4; m++)
		begin
			p = starts[m];
			pe = (m == 1 || m == 3) ? p + 21'h1 : (m == 2) ? p - 21'h1 : p;
			wa = (m == 3) ? pe : p;
			apb(1, OFS_POINTER, {11'h0, p});
			apb(1, OFS_LATCH, 32'h50 + m);
			run({TBL_OPC, 2'(m)}, 0, 2, 0);
			chk("hold", tws_far_model_i.peek(wa), 32'h50 + m);
			if (m == 3)
				chk("old", tws_far_model_i.peek(p), 32'hff);
			rdc("ptr", OFS_POINTER, {11'h0, pe});
			rdc("latch", OFS_LATCH, 32'h50 + m);
			rdc("status", OFS_STATUS, 32'h1b);
		end
		// Test-skip addressing modes and skip lengths
		ibase <= 12'h200;
		tst(0, 8'h20, 4'h5, 0, 12'h020, 0, 2);
		tst(0, 8'h20, 4'h5, 0, 12'h520, 1, 1);
		tst(0, 8'h80, 4'h0, 1, 12'hf80, 1, 3);
		tst(1, 8'h34, 4'h5, 1, 12'h534, 0, 2);
		tst(0, 8'h5f, 4'h0, 1, 12'h25f, 0, 2);
		tst(0, 8'h60, 4'h0, 1, 12'hf60, 1, 3);
		tst(0, 8'h5f, 4'h0, 0, 12'h25f, 0, 1);
		summarize();
	end
endmodule : test_table_write_skip_xor_ops

`default_nettype wire

//--- tb/tws_far_model.sv
// Far-side model: program-memory holding bytes and the register file.
// Assumes holding writes arrive as strobes sampled on the core clock edge.
`default_nettype none

module tws_far_model (
	input wire logic i_clock,
	input wire logic i_hold_we,
	input wire logic [20:0] i_hold_addr,
	input wire logic [7:0] i_hold_data,
	input wire logic [11:0] i_rf_addr,
	input wire logic [11:0] i_zero_addr,
	output logic [7:0] o_rf_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] hold [int];
	// Unwritten holding bytes read as erased
	function automatic logic [7:0] peek(input int a);
		return hold.exists(a) ? hold[a] : 8'hff;
	endfunction : peek
	// Capture on every strobed edge
	always @(posedge i_clock)
		if (i_hold_we === 1'b1)
			hold[i_hold_addr] = i_hold_data;
	// Only one cell reads zero, so a wrong bank shows as a missed skip
	assign o_rf_data = (i_rf_addr == i_zero_addr) ? 8'h00 : {i_rf_addr[6:0], 1'b1};
endmodule : tws_far_model

`default_nettype wire

//--- verilog/tws_core.sv
// Execution sequencer for table write, test-and-skip and xor-literal,
// with an APB register slave for accumulator, status, pointer, latch, bank and control.
// Assumes the register file answers I_RF_DATA in the same cycle as
// O_RF_ADDR, and the fetch unit holds I_INSTR until accepted.
//
// Chosen here: the APB slave port and the register addresses.
`default_nettype none

module tws_core
	import tws_pkg::*;
(
	input wire logic I_CLOCK,
	input wire logic I_SRST,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_INSTR_VALID,
	input wire logic [15:0] I_INSTR,
	input wire logic I_NEXT_TWO_WORD,
	output logic O_INSTR_READY,
	output logic [11:0] O_RF_ADDR,
	input wire logic [7:0] I_RF_DATA,
	input wire logic [11:0] I_INDEX_BASE,
	output logic O_HOLD_WE,
	output logic [20:0] O_HOLD_ADDR,
	output logic [7:0] O_HOLD_DATA,
	output logic O_DISCARD
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	tws_state_t state;
	tws_state_t next_state;
	logic [7:0] acc;
	logic [7:0] status;
	logic [20:0] ptr;
	logic [7:0] latch;
	logic [3:0] bank_selector;
	logic ext_en;
	logic [7:0] op_k;
	logic [1:0] op_mode;
	logic op_two;

	// Instruction decode
	wire accept = I_INSTR_VALID & O_INSTR_READY;
	wire is_xor = (I_INSTR[15:8] == XOR_OPC); // RULE11
	wire is_tst = (I_INSTR[15:9] == TST_OPC);
	wire is_tbl = (I_INSTR[15:2] == TBL_OPC);
	wire tst_a = I_INSTR[8];
	wire [7:0] tst_f = I_INSTR[7:0];

	// Operand address: indexed, banked or access bank
	wire use_index = ~tst_a & ext_en & (tst_f <= INDEX_MAX); // RULE8
	wire [11:0] idx_addr = I_INDEX_BASE + {4'h0, tst_f}; // RULE8
	wire [3:0] acc_hi = (tst_f >= ACC_SPLIT) ? ACC_HI_BANK : 4'h0;
	wire [11:0] bank_addr = tst_a ? {bank_selector, tst_f} : {acc_hi, tst_f}; // RULE7
	wire [11:0] rf_addr = use_index ? idx_addr : bank_addr;

	// Xor result and test-skip zero detect
	wire [7:0] xor_res = acc ^ op_k; // RULE9
	wire tst_zero = (I_RF_DATA == RST_BYTE);

	// Table pointer arithmetic, byte address over the full width
	wire [20:0] ptr_inc = ptr + 21'h00_0001; // RULE12
	wire [20:0] ptr_dec = ptr - 21'h00_0001;
	wire [20:0] wr_addr = (op_mode == TM_PRE_INC) ? ptr_inc : ptr; // RULE4
	wire [20:0] next_ptr = (op_mode == TM_NONE) ? ptr : (op_mode == TM_POST_DEC) ? ptr_dec
		: ptr_inc; // RULE2

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	wire apb_acc = I_PSEL & I_PENABLE & ~O_PREADY;
	wire apb_wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
	wire hit_acc = (I_PADDR == OFS_ACC);
	wire hit_st = (I_PADDR == OFS_STATUS);
	wire hit_ptr = (I_PADDR == OFS_POINTER);
	wire hit_lat = (I_PADDR == OFS_LATCH);
	wire hit_bank = (I_PADDR == OFS_BANK);
	wire hit_ctrl = (I_PADDR == OFS_CTRL);
	wire hit_any = hit_acc | hit_st | hit_ptr | hit_lat | hit_bank | hit_ctrl;
	wire hw_acc = (state == S_XOR);
	wire hw_ptr = (state == S_TBL1);
	wire [31:0] rd_mux = hit_acc ? {24'h00_0000, acc}
		: hit_st ? {24'h00_0000, status}
		: hit_ptr ? {11'h000, ptr}
		: hit_lat ? {24'h00_0000, latch}
		: hit_bank ? {28'h000_0000, bank_selector}
		: hit_ctrl ? {31'h0000_0000, ext_en}
		: 32'h0000_0000;

	// Bus answer: one wait state, unmapped offsets flag an error
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
			O_PRDATA <= 32'h0000_0000;
		end
		else
		begin
			O_PREADY <= apb_acc;
			O_PSLVERR <= apb_acc & ~hit_any;
			O_PRDATA <= apb_acc ? rd_mux : 32'h0000_0000;
		end
	end

	// Software writes; the sequencer wins a clash so no result is lost
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			latch <= RST_BYTE;
			bank_selector <= RST_BANK;
			ext_en <= 1'b0;
		end
		else if (apb_wr)
		begin
			if (hit_lat)
				latch <= I_PWDATA[7:0];
			if (hit_bank)
				bank_selector <= I_PWDATA[3:0];
			if (hit_ctrl)
				ext_en <= I_PWDATA[0];
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		case (state)
			S_IDLE:
			begin
				if (accept && is_xor)
					next_state = S_XOR;
				else if (accept && is_tst)
					next_state = S_TST;
				else if (accept && is_tbl)
					next_state = S_TBL1;
			end
			S_TST:
			begin
				if (!tst_zero)
					next_state = S_IDLE;
				else if (op_two)
					next_state = S_NOP2; // RULE6
				else
					next_state = S_NOP1; // RULE5
			end
			S_TBL1:
				next_state = S_TBL2;
			S_NOP2:
				next_state = S_NOP1;
			default:
				next_state = S_IDLE;
		endcase
	end

	// Operand capture at accept; unknown opcodes fall through idle
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			state <= S_IDLE;
			O_INSTR_READY <= 1'b0;
			op_k <= RST_BYTE;
			op_mode <= TM_NONE;
			op_two <= 1'b0;
			O_RF_ADDR <= 12'h000;
		end
		else
		begin
			state <= next_state;
			O_INSTR_READY <= (next_state == S_IDLE);
			if (accept)
			begin
				op_k <= I_INSTR[7:0]; // RULE11
				op_mode <= I_INSTR[1:0]; // RULE2
				op_two <= I_NEXT_TWO_WORD;
				O_RF_ADDR <= rf_addr;
			end
		end
	end

	// Accumulator and flags; only N and Z move on xor
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			acc <= RST_BYTE;
			status <= RST_BYTE;
		end
		else if (hw_acc)
		begin
			acc <= xor_res; // RULE9
			status[ST_N] <= xor_res[7]; // RULE10
			status[ST_Z] <= (xor_res == RST_BYTE); // RULE10
		end
		else if (apb_wr)
		begin
			if (hit_acc)
				acc <= I_PWDATA[7:0];
			if (hit_st)
				status <= I_PWDATA[7:0];
		end
	end

	// Table write: holding write strobes during the second cycle
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
		begin
			ptr <= RST_PTR;
			O_HOLD_WE <= 1'b0;
			O_HOLD_ADDR <= RST_PTR;
			O_HOLD_DATA <= RST_BYTE;
		end
		else
		begin
			O_HOLD_WE <= hw_ptr; // RULE1
			if (hw_ptr)
			begin
				O_HOLD_ADDR <= wr_addr; // RULE3 RULE4
				O_HOLD_DATA <= latch; // RULE1
				ptr <= next_ptr; // RULE3
			end
			else if (apb_wr && hit_ptr)
				ptr <= I_PWDATA[20:0];
		end
	end

	// Discard pulse for the already fetched word
	always_ff @(posedge I_CLOCK)
	begin
		if (I_SRST)
			O_DISCARD <= 1'b0;
		else
			O_DISCARD <= (state == S_TST) & tst_zero; // RULE5
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_SRST);

	sequence seq_skip_one;
		O_DISCARD && state == S_NOP1 ##1 state == S_IDLE;
	endsequence
	sequence seq_skip_two;
		O_DISCARD && state == S_NOP2 ##1 state == S_NOP1 ##1 state == S_IDLE;
	endsequence

	a_xor_result: assert property (state == S_XOR |=> acc == ($past(acc) ^ $past(op_k))) // RULE9
		else $error("xor result wrong");
	a_xor_flags: assert property (state == S_XOR |=> status[ST_N] == acc[7]
		&& status[ST_Z] == (acc == 8'h00) && status[7:5] == $past(status[7:5])
		&& status[3] == $past(status[3]) && status[1:0] == $past(status[1:0])) // RULE10
		else $error("xor flags wrong");
	a_xor_decode: assert property (accept && I_INSTR[15:8] == 8'h0a |=> state == S_XOR) // RULE11
		else $error("xor not decoded");
	a_tbl_flags: assert property (state == S_TBL1 && !(apb_wr && hit_st) |=> $stable(status)) // RULE1
		else $error("table write moved flags");
	a_tbl_data: assert property (state == S_TBL1 |=> O_HOLD_WE && O_HOLD_DATA == $past(latch)) // RULE1
		else $error("holding data wrong");
	a_post_inc: assert property (state == S_TBL1 && op_mode == 2'h1 |=>
		O_HOLD_ADDR == $past(ptr) && ptr == $past(ptr) + 21'h00_0001) // RULE3
		else $error("post increment wrong");
	a_pre_inc: assert property (state == S_TBL1 && op_mode == 2'h3 |=>
		O_HOLD_ADDR == $past(ptr) + 21'h00_0001 && ptr == O_HOLD_ADDR) // RULE4
		else $error("pre increment wrong");
	a_post_dec: assert property (state == S_TBL1 && op_mode == 2'h2 |=>
		O_HOLD_ADDR == $past(ptr) && ptr == $past(ptr) - 21'h00_0001) // RULE2
		else $error("post decrement wrong");
	a_ptr_keep: assert property (state == S_TBL1 && op_mode == 2'h0 |=>
		O_HOLD_ADDR == $past(ptr) && ptr == $past(ptr)) // RULE2
		else $error("pointer moved without mode");
	a_skip_one: assert property (state == S_TST && tst_zero && !op_two |=> seq_skip_one) // RULE5
		else $error("single skip wrong");
	a_skip_two: assert property (state == S_TST && tst_zero && op_two |=> seq_skip_two) // RULE6
		else $error("double skip wrong");
	a_no_skip: assert property (state == S_TST && !tst_zero |=> state == S_IDLE && !O_DISCARD) // RULE5
		else $error("skip without zero");
	a_bank_sel: assert property (accept && is_tst && tst_a |=>
		O_RF_ADDR == {$past(bank_selector), $past(tst_f)}) // RULE7
		else $error("banked address wrong");
	a_access_bank: assert property (accept && is_tst && !tst_a && !(ext_en && tst_f <= 8'h5f)
		|=> O_RF_ADDR == {(($past(tst_f[7]) || $past(tst_f[6:5]) == 2'b11) ? 4'hf : 4'h0),
		$past(tst_f)}) // RULE7
		else $error("access bank address wrong");
	a_index_mode: assert property (accept && is_tst && !tst_a && ext_en && tst_f <= 8'h5f |=>
		O_RF_ADDR == $past(I_INDEX_BASE) + {4'h0, $past(tst_f)}) // RULE8
		else $error("indexed address wrong");
endmodule : tws_core

`default_nettype wire

//--- verilog/tws_pkg.sv
// Constants, state codes and register map for the table-write, test-skip
// and xor-literal execution block.
// Assumes a single 100 MHz clock and APB with 32-bit data.
//
// Operation
// [RULE1] Table write copies the latch byte to the pointed holding location, flags untouched
// [RULE2] Table write low two opcode bits pick none, post-inc, post-dec, pre-inc
// [RULE3] Post-increment writes at the old pointer, then advances the pointer
// [RULE4] Pre-increment advances first, writes at the new address only
// [RULE5] Test-skip on zero discards the fetched next word, one extra cycle
// [RULE6] Skipping a two-word instruction costs two extra cycles, three total
// [RULE7] Bank bit clear uses access bank, set uses the bank selector
// [RULE8] Bank clear, extension on, address up to 95 gives indexed literal offset
// [RULE9] Xor-literal: accumulator xor immediate back into the accumulator
// [RULE10] Xor-literal updates only negative and zero flags
// [RULE11] Xor-literal decoded from the upper opcode byte, immediate in low byte
// [RULE12] Table pointer is 21 bits, byte addressed, bit 0 picks the word byte
`default_nettype none

package tws_pkg;
	// ------------------------------------------------------------
	// Opcodes and widths
	// ------------------------------------------------------------
	localparam int TP_WIDTH = 21;
	localparam int RF_AW = 12;
	localparam logic [7:0] XOR_OPC = 8'h0a;
	localparam logic [6:0] TST_OPC = 7'h33;
	localparam logic [13:0] TBL_OPC = 14'h0003;
	localparam logic [1:0] TM_NONE = 2'h0;
	localparam logic [1:0] TM_POST_INC = 2'h1;
	localparam logic [1:0] TM_POST_DEC = 2'h2;
	localparam logic [1:0] TM_PRE_INC = 2'h3;
	localparam logic [7:0] INDEX_MAX = 8'h5f;
	localparam logic [7:0] ACC_SPLIT = 8'h60;
	localparam logic [3:0] ACC_HI_BANK = 4'hf;
	// ------------------------------------------------------------
	// Status bits
	// ------------------------------------------------------------
	localparam int ST_Z = 2;
	localparam int ST_N = 4;
	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_ACC = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_POINTER = 8'h08;
	localparam logic [7:0] OFS_LATCH = 8'h0c;
	localparam logic [7:0] OFS_BANK = 8'h10;
	localparam logic [7:0] OFS_CTRL = 8'h14;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [20:0] RST_PTR = 21'h00_0000;
	localparam logic [3:0] RST_BANK = 4'h0;
	// ------------------------------------------------------------
	// Sequencer states
	// ------------------------------------------------------------
	typedef enum logic [6:0] {
		S_IDLE = 7'b000_0001,
		S_XOR = 7'b000_0010,
		S_TST = 7'b000_0100,
		S_TBL1 = 7'b000_1000,
		S_TBL2 = 7'b001_0000,
		S_NOP2 = 7'b010_0000,
		S_NOP1 = 7'b100_0000
	} tws_state_t;
endpackage : tws_pkg

`default_nettype wire
